// *** logic/mfp_pkg.sv ***
// constants for the multifunction pin select block
// assumes a 32-bit apb slave with byte addresses in paddr[7:0]
package mfp_pkg;

    localparam int NUM_PORTS = 4;
    localparam int NUM_PINS  = 4;

    // receive-side function codes
    localparam logic [3:0] RX_TERM_IN  = 4'h8;
    localparam logic [3:0] RX_GPI      = 4'h9;
    localparam logic [3:0] RX_OUT_HIGH = 4'hA;
    localparam logic [3:0] RX_OUT_LOW  = 4'hB;
    localparam logic [3:0] RX_LOS_OUT  = 4'hC;
    localparam logic [3:0] RX_NEG_OUT  = 4'hE;
    localparam logic [3:0] RX_CLK_OUT  = 4'hF;

    // transmit-side function codes
    localparam logic [3:0] TX_CLK_IN   = 4'h3;
    localparam logic [3:0] TX_CLK_OUT  = 4'h7;
    localparam logic [3:0] TX_TRI_HIGH = 4'h8;
    localparam logic [3:0] TX_GPI      = 4'h9;
    localparam logic [3:0] TX_OUT_HIGH = 4'hA;
    localparam logic [3:0] TX_OUT_LOW  = 4'hB;
    localparam logic [3:0] TX_NEG_IN   = 4'hD;
    localparam logic [3:0] TX_TRI_LOW  = 4'hE;

    // register map: one 32-byte block per port
    localparam int         PORT_ADDR_LSB  = 5;
    localparam logic [2:0] IDX_PIN_CFG_A  = 3'h0;
    localparam logic [2:0] IDX_PIN_CFG_D  = 3'h3;
    localparam logic [2:0] IDX_CONTROL    = 3'h4;
    localparam logic [2:0] IDX_STATUS     = 3'h5;

    // pin config word fields
    localparam int RX_CODE_LSB = 0;
    localparam int TX_CODE_LSB = 4;
    localparam logic [7:0] PIN_CFG_RESET = 8'h0F;

    // control word fields
    localparam int CTRL_WIDTH       = 14;
    localparam int CTL_RX_EDGE      = 0;
    localparam int CTL_TX_EDGE      = 1;
    localparam int CTL_TERM_SW      = 2;
    localparam int CTL_RX_DUAL      = 3;
    localparam int CTL_TX_DUAL      = 4;
    localparam int CTL_CLK_OE       = 5;
    localparam int CTL_COMPAT       = 6;
    localparam int CTL_RX_CLK_DIR   = 7;
    localparam int CTL_TX_TRI       = 8;
    localparam int CTL_SRC_B_LSB    = 9;
    localparam int CTL_SRC_A_LSB    = 12;
    localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 14'h0000;

    // status word fields
    localparam int STS_RX_GPI_LSB = 0;
    localparam int STS_TX_GPI_LSB = 4;
    localparam int STS_LOS        = 8;
    localparam int STS_TERM_SW    = 9;
    localparam int STS_TX_HIZ     = 10;

endpackage

// *** logic/edge_if.sv ***
// carrier between the pin logic and one clock edge detector
// level is already synchronous to pclk
`timescale 1ns/1ps
`default_nettype none
interface edge_if;
    logic level;
    logic falling_sel;
    logic strobe;
    modport detector (input level, input falling_sel, output strobe);
    modport user     (output level, output falling_sel, input strobe);
endinterface
`default_nettype wire

// *** logic/edge_strobe.sv ***
// chosen-edge strobe from a sampled framer clock level
// assumes the level input is synchronous to pclk
`timescale 1ns/1ps
`default_nettype none
module edge_strobe (
    input  wire logic   pclk,
    input  wire logic   presetn,
    edge_if.detector    edge_port
);
    logic prev;
    logic armed;

    // first sample after reset only loads, so no false edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev  <= 1'b0;
            armed <= 1'b0;
        end else begin
            prev  <= edge_port.level;
            armed <= 1'b1;
        end
    end

    assign edge_port.strobe = armed & (edge_port.falling_sel ? (prev & ~edge_port.level)
                                                            : (~prev & edge_port.level));
endmodule // edge_strobe
`default_nettype wire

// *** logic/multifunction_pin_select.sv ***
// multifunction pin select for four line-interface ports, apb register access
// assumes framer clocks and pin inputs are synchronous to pclk
// Function
// - four rx pins, each with 4-bit code
// - reset as inputs, code sets direction
// - rx pins use chosen framer rx edge
// - code 1000: termination XNOR register bit
// - code 1001: rx level in status
// - codes 1010/1011 drive rx high/low
// - code 1100 outputs loss-of-signal status
// - code 1110: negative rail or violations
// - code 1111 rx clock, enable, source
// - tx pins use chosen framer tx edge
// - code 0011 takes framer transmit clock
// - code 0111 outputs transmit line clock
// - code 1000 high forces line hiz
// - code 1110 low forces line hiz
// - code 1001: tx level in status
// - codes 1010/1011 drive tx high/low
// - code 1101 latches negative tx data
// - rx framer clock direction by bit
`timescale 1ns/1ps
`default_nettype none
module multifunction_pin_select (
    input  wire logic                                          pclk,
    input  wire logic                                          presetn,
    input  wire logic                                          psel,
    input  wire logic                                          penable,
    input  wire logic                                          pwrite,
    input  wire logic [7:0]                                    paddr,
    input  wire logic [31:0]                                   pwdata,
    output logic      [31:0]                                   prdata,
    output logic                                               pready,
    output logic                                               pslverr,
    input  wire logic [mfp_pkg::NUM_PORTS-1:0][mfp_pkg::NUM_PINS-1:0] rx_multi_pin_in,
    output logic      [mfp_pkg::NUM_PORTS-1:0][mfp_pkg::NUM_PINS-1:0] rx_multi_pin_out,
    output logic      [mfp_pkg::NUM_PORTS-1:0][mfp_pkg::NUM_PINS-1:0] rx_multi_pin_oe,
    output logic      [mfp_pkg::NUM_PORTS-1:0][mfp_pkg::NUM_PINS-1:0] rx_multi_pin_pullup,
    input  wire logic [mfp_pkg::NUM_PORTS-1:0][mfp_pkg::NUM_PINS-1:0] tx_multi_pin_in,
    output logic      [mfp_pkg::NUM_PORTS-1:0][mfp_pkg::NUM_PINS-1:0] tx_multi_pin_out,
    output logic      [mfp_pkg::NUM_PORTS-1:0][mfp_pkg::NUM_PINS-1:0] tx_multi_pin_oe,
    output logic      [mfp_pkg::NUM_PORTS-1:0][mfp_pkg::NUM_PINS-1:0] tx_multi_pin_pullup,
    input  wire logic [mfp_pkg::NUM_PORTS-1:0]                 framer_rx_clock_in,
    output logic      [mfp_pkg::NUM_PORTS-1:0]                 framer_rx_clock_out,
    output logic      [mfp_pkg::NUM_PORTS-1:0]                 framer_rx_clock_oe,
    input  wire logic [mfp_pkg::NUM_PORTS-1:0]                 framer_rx_clock_gen,
    input  wire logic [mfp_pkg::NUM_PORTS-1:0]                 framer_tx_clock,
    input  wire logic [mfp_pkg::NUM_PORTS-1:0]                 signal_loss_status,
    input  wire logic [mfp_pkg::NUM_PORTS-1:0]                 rx_negative_rail_data,
    input  wire logic [mfp_pkg::NUM_PORTS-1:0]                 rx_bipolar_violation,
    input  wire logic [mfp_pkg::NUM_PORTS-1:0]                 rx_clock_src,
    output logic      [mfp_pkg::NUM_PORTS-1:0][2:0]            rx_clock_source_sel,
    input  wire logic [mfp_pkg::NUM_PORTS-1:0]                 tx_line_clock,
    output logic      [mfp_pkg::NUM_PORTS-1:0]                 termination_switch_ctl,
    output logic      [mfp_pkg::NUM_PORTS-1:0]                 tx_line_hiz,
    output logic      [mfp_pkg::NUM_PORTS-1:0]                 tx_clock_input,
    output logic      [mfp_pkg::NUM_PORTS-1:0]                 tx_clock_input_valid,
    output logic      [mfp_pkg::NUM_PORTS-1:0]                 tx_negative_rail_in,
    output logic      [mfp_pkg::NUM_PORTS-1:0]                 tx_negative_rail_valid
);

    localparam int NP = mfp_pkg::NUM_PORTS;
    localparam int NK = mfp_pkg::NUM_PINS;

    // configuration state
    logic [NK-1:0][7:0]               pin_config_regs [NP];
    logic [mfp_pkg::CTRL_WIDTH-1:0]   ctrl [NP];
    logic [31:0]                      status_word [NP];

    // apb decode
    logic [1:0] sel_port;
    logic [2:0] sel_idx;
    logic       addr_ok;
    logic       setup_phase;
    logic       access_phase;
    logic [31:0] next_prdata;

    assign sel_port     = paddr[mfp_pkg::PORT_ADDR_LSB +: 2];
    assign sel_idx      = paddr[4:2];
    assign addr_ok      = (sel_idx <= mfp_pkg::IDX_STATUS) && (paddr[1:0] == 2'h0);
    assign setup_phase  = psel & ~penable;
    assign access_phase = psel & penable;
    // read data is captured in setup, so a zero-wait access still answers from a flop
    assign pready       = 1'b1;

    always_comb begin
        next_prdata = 32'h0000_0000;
        if (addr_ok) begin
            if (sel_idx <= mfp_pkg::IDX_PIN_CFG_D) begin
                next_prdata = {24'h00_0000, pin_config_regs[sel_port][sel_idx[1:0]]};
            end else if (sel_idx == mfp_pkg::IDX_CONTROL) begin
                next_prdata = {18'h0_0000, ctrl[sel_port]};
            end else begin
                next_prdata = status_word[sel_port];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup_phase) begin
            prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
            // status is read-only, a write there is refused too
            pslverr <= ~addr_ok | (pwrite & (sel_idx == mfp_pkg::IDX_STATUS));
        end
    end

    // register writes take effect at the access edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int p = 0; p < NP; p++) begin
                for (int k = 0; k < NK; k++) begin
                    pin_config_regs[p][k] <= mfp_pkg::PIN_CFG_RESET;
                end
                ctrl[p] <= mfp_pkg::CTRL_RESET;
            end
        end else if (access_phase && pwrite && addr_ok) begin
            if (sel_idx <= mfp_pkg::IDX_PIN_CFG_D) begin
                pin_config_regs[sel_port][sel_idx[1:0]] <= pwdata[7:0];
            end else if (sel_idx == mfp_pkg::IDX_CONTROL) begin
                ctrl[sel_port] <= pwdata[mfp_pkg::CTRL_WIDTH-1:0];
            end
        end
    end

    for (genvar p = 0; p < NP; p++) begin : g_port
        edge_if rx_edge ();
        edge_if tx_edge ();

        logic [NK-1:0] rx_lat;
        logic [NK-1:0] tx_lat;
        logic [NK-1:0] rx_gpi;
        logic [NK-1:0] tx_gpi;
        logic [NK-1:0] rlt_ok;
        logic [NK-1:0] tri_hit;
        logic [NK-1:0] clkin_hit;
        logic [NK-1:0] clkin_lvl;
        logic [NK-1:0] neg_hit;
        logic [NK-1:0] neg_lvl;
        logic          rx_dir_out;

        assign rx_dir_out = ctrl[p][mfp_pkg::CTL_RX_CLK_DIR];

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                framer_rx_clock_out[p] <= 1'b0;
                framer_rx_clock_oe[p]  <= 1'b0;
            end else begin
                framer_rx_clock_out[p] <= framer_rx_clock_gen[p];
                framer_rx_clock_oe[p]  <= rx_dir_out;
            end
        end

        assign rx_edge.level       = framer_rx_clock_oe[p] ? framer_rx_clock_out[p] : framer_rx_clock_in[p];
        assign rx_edge.falling_sel = ctrl[p][mfp_pkg::CTL_RX_EDGE];
        assign tx_edge.level       = framer_tx_clock[p];
        assign tx_edge.falling_sel = ctrl[p][mfp_pkg::CTL_TX_EDGE];

        edge_strobe u_rx_edge (
            .pclk      (pclk),
            .presetn   (presetn),
            .edge_port (rx_edge.detector)
        );

        edge_strobe u_tx_edge (
            .pclk      (pclk),
            .presetn   (presetn),
            .edge_port (tx_edge.detector)
        );

        for (genvar k = 0; k < NK; k++) begin : g_pin
            logic [3:0] rx_code;
            logic [3:0] tx_code;
            logic       next_rx_out;
            logic       next_rx_oe;
            logic       next_tx_out;
            logic       next_tx_oe;

            assign rx_code = pin_config_regs[p][k][mfp_pkg::RX_CODE_LSB +: 4];
            assign tx_code = pin_config_regs[p][k][mfp_pkg::TX_CODE_LSB +: 4];

            // input levels latched on the chosen framer edge
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    rx_lat[k] <= 1'b1;
                end else if (rx_edge.strobe) begin
                    rx_lat[k] <= rx_multi_pin_in[p][k];
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    tx_lat[k] <= 1'b1;
                end else if (tx_edge.strobe) begin
                    tx_lat[k] <= tx_multi_pin_in[p][k];
                end
            end

            always_comb begin
                next_rx_out = rx_multi_pin_out[p][k];
                next_rx_oe  = 1'b0;
                case (rx_code)
                    mfp_pkg::RX_OUT_HIGH: begin
                        next_rx_out = 1'b1;
                        next_rx_oe  = 1'b1;
                    end
                    mfp_pkg::RX_OUT_LOW: begin
                        next_rx_out = 1'b0;
                        next_rx_oe  = 1'b1;
                    end
                    mfp_pkg::RX_LOS_OUT: begin
                        if (rx_edge.strobe) begin
                            next_rx_out = signal_loss_status[p];
                        end
                        next_rx_oe = 1'b1;
                    end
                    mfp_pkg::RX_NEG_OUT: begin
                        if (rx_edge.strobe) begin
                            next_rx_out = ctrl[p][mfp_pkg::CTL_RX_DUAL] ? rx_negative_rail_data[p]
                                                                         : rx_bipolar_violation[p];
                        end
                        next_rx_oe = 1'b1;
                    end
                    mfp_pkg::RX_CLK_OUT: begin
                        next_rx_out = rx_clock_src[p];
                        next_rx_oe  = ctrl[p][mfp_pkg::CTL_CLK_OE];
                    end
                    default: begin
                        next_rx_out = 1'b0;
                        next_rx_oe  = 1'b0;
                    end
                endcase
            end

            always_comb begin
                next_tx_out = 1'b0;
                next_tx_oe  = 1'b0;
                case (tx_code)
                    mfp_pkg::TX_CLK_OUT: begin
                        next_tx_out = tx_line_clock[p];
                        next_tx_oe  = 1'b1;
                    end
                    mfp_pkg::TX_OUT_HIGH: begin
                        next_tx_out = 1'b1;
                        next_tx_oe  = 1'b1;
                    end
                    // low code follows its name, not the printed level
                    mfp_pkg::TX_OUT_LOW: begin
                        next_tx_out = 1'b0;
                        next_tx_oe  = 1'b1;
                    end
                    default: begin
                        next_tx_out = 1'b0;
                        next_tx_oe  = 1'b0;
                    end
                endcase
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    rx_multi_pin_out[p][k] <= 1'b0;
                    rx_multi_pin_oe[p][k]  <= 1'b0;
                    tx_multi_pin_out[p][k] <= 1'b0;
                    tx_multi_pin_oe[p][k]  <= 1'b0;
                end else begin
                    rx_multi_pin_out[p][k] <= next_rx_out;
                    rx_multi_pin_oe[p][k]  <= next_rx_oe;
                    tx_multi_pin_out[p][k] <= next_tx_out;
                    tx_multi_pin_oe[p][k]  <= next_tx_oe;
                end
            end

            assign rx_multi_pin_pullup[p][k] = ~rx_multi_pin_oe[p][k];
            assign tx_multi_pin_pullup[p][k] = ~tx_multi_pin_oe[p][k];

            assign rx_gpi[k]    = (rx_code == mfp_pkg::RX_GPI) & rx_lat[k];
            assign tx_gpi[k]    = (tx_code == mfp_pkg::TX_GPI) & tx_lat[k];
            assign rlt_ok[k]    = (rx_code != mfp_pkg::RX_TERM_IN) | rx_lat[k];
            assign tri_hit[k]   = ((tx_code == mfp_pkg::TX_TRI_HIGH) & tx_lat[k]) |
                                  ((tx_code == mfp_pkg::TX_TRI_LOW) & ~tx_lat[k]);
            assign clkin_hit[k] = (tx_code == mfp_pkg::TX_CLK_IN);
            assign clkin_lvl[k] = clkin_hit[k] & tx_multi_pin_in[p][k];
            assign neg_hit[k]   = (tx_code == mfp_pkg::TX_NEG_IN);
            assign neg_lvl[k]   = neg_hit[k] & tx_lat[k];
        end

        assign rx_clock_source_sel[p] = ctrl[p][mfp_pkg::CTL_COMPAT]
                                      ? {1'b0, ctrl[p][mfp_pkg::CTL_SRC_A_LSB +: 2]}
                                      : ctrl[p][mfp_pkg::CTL_SRC_B_LSB +: 3];

        // each input function is selected once, so or-reducing is safe
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                termination_switch_ctl[p] <= 1'b0;
                tx_line_hiz[p]            <= 1'b1;
                tx_clock_input[p]         <= 1'b0;
                tx_clock_input_valid[p]   <= 1'b0;
            end else begin
                termination_switch_ctl[p] <= ~((&rlt_ok) ^ ctrl[p][mfp_pkg::CTL_TERM_SW]);
                tx_line_hiz[p]            <= (|tri_hit) | ctrl[p][mfp_pkg::CTL_TX_TRI];
                tx_clock_input[p]         <= |clkin_lvl;
                tx_clock_input_valid[p]   <= |clkin_hit;
            end
        end

        // latched on tx edge in dual rail
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                tx_negative_rail_in[p]    <= 1'b0;
                tx_negative_rail_valid[p] <= 1'b0;
            end else begin
                tx_negative_rail_valid[p] <= (|neg_hit) & ctrl[p][mfp_pkg::CTL_TX_DUAL];
                if (tx_edge.strobe) begin
                    tx_negative_rail_in[p] <= (|neg_lvl) & ctrl[p][mfp_pkg::CTL_TX_DUAL];
                end
            end
        end

        always_comb begin
            status_word[p]                                 = 32'h0000_0000;
            status_word[p][mfp_pkg::STS_RX_GPI_LSB +: NK]  = rx_gpi;
            status_word[p][mfp_pkg::STS_TX_GPI_LSB +: NK]  = tx_gpi;
            status_word[p][mfp_pkg::STS_LOS]               = signal_loss_status[p];
            status_word[p][mfp_pkg::STS_TERM_SW]           = termination_switch_ctl[p];
            status_word[p][mfp_pkg::STS_TX_HIZ]            = tx_line_hiz[p];
        end
    end

endmodule // multifunction_pin_select
`default_nettype wire

// *** testbench/framer_model.sv ***
// framer side: free running framer rx and tx clocks
// assumes pclk of 25 ns; framer clocks run at a quarter of it
`timescale 1ns/1ps
`default_nettype none
module framer_model (
    input  wire logic  pclk,
    output logic [3:0] rx_clock,
    output logic [3:0] tx_clock,
    output logic [3:0] gen_clock
);
    logic [1:0] div = 2'h0;
    always @(posedge pclk) begin
        div <= div + 2'h1;
    end
    assign rx_clock  = {4{div[1]}};
    // tx a quarter period early, so edges never coincide
    assign tx_clock  = {4{div[1] ^ div[0]}};
    assign gen_clock = {4{~div[1]}};
endmodule // framer_model
`default_nettype wire

// *** testbench/mfp_asserts.sv ***
// port checks for the multifunction pin select block
// bound onto the top module, one pclk domain
`timescale 1ns/1ps
`default_nettype none
module mfp_asserts (
    input wire logic            pclk,
    input wire logic            presetn,
    input wire logic            psel,
    input wire logic            penable,
    input wire logic            pwrite,
    input wire logic [7:0]      paddr,
    input wire logic [31:0]     prdata,
    input wire logic            pslverr,
    input wire logic [3:0][3:0] rx_multi_pin_oe,
    input wire logic [3:0][3:0] rx_multi_pin_pullup,
    input wire logic [3:0][3:0] tx_multi_pin_oe,
    input wire logic [3:0][3:0] tx_multi_pin_pullup,
    input wire logic [3:0]      framer_rx_clock_gen,
    input wire logic [3:0]      framer_rx_clock_out,
    input wire logic [3:0]      framer_rx_clock_oe
);
    logic wr;
    assign wr = psel && penable && pwrite;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_rx_pull_inv: assert property (rx_multi_pin_pullup == ~rx_multi_pin_oe)
        else $error("rx pull-up wrong");
    chk_tx_pull_inv: assert property (tx_multi_pin_pullup == ~tx_multi_pin_oe)
        else $error("tx pull-up wrong");
    chk_rx_dir_cause: assert property ($changed(rx_multi_pin_oe) |-> $past(wr) || $past(wr, 2) || $past(wr, 3))
        else $error("rx direction changed unprompted");
    chk_clk_dir_cause: assert property ($changed(framer_rx_clock_oe) |-> $past(wr) || $past(wr, 2))
        else $error("clock direction changed unprompted");
    chk_clk_follow: assert property ((framer_rx_clock_out & framer_rx_clock_oe)
        == ($past(framer_rx_clock_gen) & framer_rx_clock_oe)) else $error("driven clock wrong");
    chk_err_align: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
        else $error("misaligned not refused");
    chk_err_status: assert property (psel && !penable && pwrite && paddr[4:2] == 3'h5 |=> pslverr)
        else $error("status write not refused");
    chk_err_rdzero: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
        else $error("refused read not zero");
    cov_cfg_write: cover property (wr && paddr[4:2] == 3'h0);
    cov_refused: cover property (pslverr);
    cov_clk_drive: cover property (|framer_rx_clock_oe);
endmodule // mfp_asserts
bind multifunction_pin_select mfp_asserts chk (.*);
`default_nettype wire

// *** testbench/tb_top.sv ***
// self-checking bench for the multifunction pin select block
// framer clocks from framer_model, registers over apb
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0][3:0] rx_multi_pin_in, rx_multi_pin_out, rx_multi_pin_oe, rx_multi_pin_pullup, rx_drv;
    logic [3:0][3:0] tx_multi_pin_in, tx_multi_pin_out, tx_multi_pin_oe, tx_multi_pin_pullup, tx_drv;
    logic [3:0] framer_rx_clock_in, framer_rx_clock_out, framer_rx_clock_oe, framer_rx_clock_gen, fr_rck;
    logic [3:0] framer_tx_clock, signal_loss_status, rx_negative_rail_data, rx_bipolar_violation;
    logic [3:0] rx_clock_src, tx_line_clock, termination_switch_ctl, tx_line_hiz, tx_clock_input;
    logic [3:0] tx_clock_input_valid, tx_negative_rail_in, tx_negative_rail_valid;
    logic [3:0][2:0] rx_clock_source_sel;
    int failures = 0, checks = 0;
    // rx code, tx code, then rx oe, rx level, tx oe, tx level
    logic [11:0] rows [9] = '{12'h830, 12'h973, 12'hA8C, 12'hB98, 12'hCAF, 12'hEBE, 12'hFD0, 12'h0E0, 12'h510};
    assign rx_multi_pin_in = (rx_multi_pin_oe & rx_multi_pin_out) | (~rx_multi_pin_oe & rx_drv);
    assign tx_multi_pin_in = (tx_multi_pin_oe & tx_multi_pin_out) | (~tx_multi_pin_oe & tx_drv);
    assign framer_rx_clock_in = (framer_rx_clock_oe & framer_rx_clock_out) | (~framer_rx_clock_oe & fr_rck);
    always #12.5 pclk = ~pclk;
    multifunction_pin_select uut (.*);
    framer_model partner (.pclk(pclk), .rx_clock(fr_rck), .tx_clock(framer_tx_clock), .gen_clock(framer_rx_clock_gen));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        rd = prdata;
        er = pslverr;
        if (n >= 40) failures++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic complete_run;
        if (failures == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #100000;
        failures++;
        complete_run;
    end
    initial begin
        rx_drv = '1;
        tx_drv = '1;
        signal_loss_status = 4'h1;
        rx_negative_rail_data = 4'h0;
        rx_bipolar_violation = 4'h1;
        rx_clock_src = 4'h0;
        tx_line_clock = 4'h1;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        idle(2);
        check({rx_multi_pin_oe, tx_multi_pin_oe}, 32'h0);
        apb(1'b0, 8'h00, 32'h0);
        check(rd, 32'h0000000F);
        apb(1'b0, 8'h18, 32'h0);
        check({er, rd[30:0]}, 32'h80000000);
        foreach (rows[i]) begin
            apb(1'b1, 8'h00, {24'h0, rows[i][7:4], rows[i][11:8]});
            idle(12);
            check({rx_multi_pin_oe[0][0], rx_multi_pin_out[0][0] & rx_multi_pin_oe[0][0], tx_multi_pin_oe[0][0],
                   tx_multi_pin_out[0][0] & tx_multi_pin_oe[0][0]}, rows[i][3:0]);
        end
        apb(1'b1, 8'h00, 32'h08);
        rx_drv[0][0] <= 1'b0;
        idle(8);
        check(termination_switch_ctl[0], 1'b1);
        apb(1'b1, 8'h10, 32'h05);
        idle(8);
        check(termination_switch_ctl[0], 1'b0);
        apb(1'b1, 8'h00, 32'h0E);
        apb(1'b1, 8'h10, 32'h08);
        idle(8);
        check(rx_multi_pin_out[0][0], 1'b0);
        @(posedge pclk) rx_negative_rail_data <= 4'h1;
        idle(8);
        check(rx_multi_pin_out[0][0], 1'b1);
        @(posedge fr_rck[0]);
        @(posedge pclk) rx_negative_rail_data <= 4'h0;
        idle(2);
        check(rx_multi_pin_out[0][0], 1'b1);
        apb(1'b1, 8'h10, 32'h09);
        @(posedge fr_rck[0]);
        @(posedge pclk) rx_negative_rail_data <= 4'h1;
        idle(2);
        check(rx_multi_pin_out[0][0], 1'b1);
        apb(1'b1, 8'h00, 32'h80);
        idle(8);
        check(tx_line_hiz[0], 1'b1);
        apb(1'b1, 8'h00, 32'hE0);
        idle(8);
        check(tx_line_hiz[0], 1'b0);
        apb(1'b1, 8'h10, 32'h02);
        @(posedge framer_tx_clock[0]);
        @(posedge pclk) tx_drv[0][0] <= 1'b0;
        idle(3);
        check(tx_line_hiz[0], 1'b1);
        idle(5);
        check(tx_line_hiz[0], 1'b1);
        apb(1'b1, 8'h10, 32'h110);
        tx_drv[0][0] <= 1'b1;
        idle(8);
        check(tx_line_hiz[0], 1'b1);
        apb(1'b1, 8'h00, 32'hD0);
        idle(8);
        check({tx_negative_rail_valid[0], tx_negative_rail_in[0]}, 2'h3);
        apb(1'b1, 8'h00, 32'h30);
        idle(2);
        check({tx_clock_input_valid[0], tx_clock_input[0]}, 2'h3);
        @(posedge pclk) tx_drv[0][0] <= 1'b0;
        idle(2);
        check({tx_clock_input_valid[0], tx_clock_input[0]}, 2'h2);
        apb(1'b1, 8'h10, 32'h0);
        rx_drv[0] <= 4'h5;
        tx_drv[0] <= 4'hA;
        for (int p = 0; p < 4; p++) apb(1'b1, 8'(p * 4), 32'h99);
        idle(8);
        apb(1'b0, 8'h14, 32'h0);
        check(rd, 32'h000001A5);
        check(rd[7:4], 4'hA);
        apb(1'b1, 8'h14, 32'h0);
        check(er, 1'b1);
        apb(1'b1, 8'h02, 32'hFF);
        check(er, 1'b1);
        apb(1'b1, 8'h30, 32'h2060);
        idle(3);
        check({rx_multi_pin_oe[1], rx_clock_source_sel[1]}, 7'h7A);
        apb(1'b1, 8'h30, 32'hA80);
        idle(3);
        check({framer_rx_clock_oe[1], rx_clock_source_sel[1]}, 4'hD);
        check(rx_multi_pin_oe[1], 4'h0);
        complete_run;
    end
endmodule // tb_top
`default_nettype wire
